// >>> rtl/rxs_pkg.sv
package rxs_pkg;

    // register offsets on the bus (byte addresses, low address byte)
    localparam logic [7:0]  OFS_CTL      = 8'h00;   // host_mac_control_reg
    localparam logic [7:0]  OFS_STAT     = 8'h04;   // status word port, read pops
    localparam logic [7:0]  OFS_INFO     = 8'h08;   // fill level and lost-word count

    // host_mac_control_reg fields and reset value
    localparam int          CTL_PASS_BAD = 0;        // pass_bad_frames_ctl
    localparam int          CTL_SPEED10  = 1;        // link runs at 10 Mbps
    localparam logic [1:0]  CTL_RST      = 2'h0;

    // info register layout
    localparam int          INFO_LVL_LO  = 0;        // used words, bits 15:0
    localparam int          INFO_DROP_LO = 16;       // lost words, bits 31:16

    // status word bit positions
    localparam int          B_FILT       = 31;
    localparam int          B_DA_FAIL    = 30;
    localparam int          B_LEN_HI     = 29;
    localparam int          B_LEN_LO     = 16;
    localparam int          B_ES         = 15;       // error_summary_bit
    localparam int          B_BCAST      = 13;
    localparam int          B_LEN_ERR    = 12;       // length_mismatch_flag
    localparam int          B_RUNT       = 11;
    localparam int          B_MCAST      = 10;
    localparam int          B_LONG       = 7;
    localparam int          B_LATE_COL   = 6;
    localparam int          B_TYPE       = 5;
    localparam int          B_WDOG       = 4;
    localparam int          B_MII        = 3;
    localparam int          B_DRIB       = 2;
    localparam int          B_CRC        = 1;

    // frame length limits, byte counts
    localparam int          CNT_W        = 12;
    localparam logic [11:0] RUNT_BYTES   = 12'h040;  // 64, collision window
    localparam logic [11:0] LONG_BYTES   = 12'h5EE;  // 1518
    localparam logic [11:0] WDOG_BYTES   = 12'h800;  // 2048, also the truncation point
    localparam logic [11:0] HDR_BYTES    = 12'h00E;  // 14, header with length/type
    localparam logic [11:0] DA_BYTES     = 12'h006;  // destination address bytes
    localparam logic [11:0] LT_HI_IDX    = 12'h00C;  // length/type high byte index
    localparam logic [11:0] LT_LO_IDX    = 12'h00D;  // length/type low byte index
    localparam logic [15:0] TYPE_MIN     = 16'h05DC; // 1500
    localparam logic [15:0] PAD_LIMIT    = 16'h002E; // 46, payloads below this are padded
    localparam logic [15:0] OVERHEAD     = 16'h0012; // 18, header plus check sequence
    localparam logic [2:0]  DRIB_MIN     = 3'h3;     // extra bits needed at 10 Mbps
    localparam logic [7:0]  BCAST_BYTE   = 8'hFF;

endpackage

// >>> rtl/rxs_res_if.sv
`timescale 1ns/1ps
`default_nettype none

// per-frame results from the byte meter to the status word builder
interface rxs_res_if;
    logic        done;       // one-cycle pulse, results below are final
    logic [11:0] bytes;      // bytes delivered, saturates at 2048
    logic        bcast;      // destination all ones
    logic        mcast;      // group bit set in destination
    logic [15:0] len_type;   // length/type field
    logic        rx_er;      // receive error seen during the frame
    logic        late_col;   // late collision seen during the frame
    logic        crc_bad;    // check sequence failed
    logic [2:0]  drib_bits;  // extra bits past the last whole byte
    logic        filt_pass;  // frame filter passed
    logic        da_fail;    // address recognition failed

    modport meter (output done, bytes, bcast, mcast, len_type, rx_er, late_col,
                   crc_bad, drib_bits, filt_pass, da_fail);
    modport gen   (input  done, bytes, bcast, mcast, len_type, rx_er, late_col,
                   crc_bad, drib_bits, filt_pass, da_fail);
endinterface

`default_nettype wire

// >>> rtl/rxs_stat_mem.sv
`timescale 1ns/1ps
`default_nettype none

// status word storage, one write and one registered read port
module rxs_stat_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          ce,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    // read port
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata_q
);

    logic [W-1:0] mem [DEPTH];   // word array, no reset needed

    // write side
    always_ff @(posedge hclk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data leaves through a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= '0;
        end else if (ce && re) begin
            rdata_q <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

// >>> rtl/rxs_frame_meter.sv
`timescale 1ns/1ps
`default_nettype none

// counts frame bytes, watches the header and cuts frames at 2048 bytes
module rxs_frame_meter (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ce,
    // frame bytes from the fabric
    input  wire logic       frm_valid,
    input  wire logic [7:0] frm_data,
    input  wire logic       frm_last,
    input  wire logic       frm_rx_er,
    input  wire logic       frm_late_col,
    input  wire logic       frm_crc_bad,
    input  wire logic [2:0] frm_drib_bits,
    input  wire logic       frm_filt_pass,
    input  wire logic       frm_da_fail,
    // bytes towards the data queue
    output logic            rxd_valid,
    output logic      [7:0] rxd_data,
    // per-frame results
    rxs_res_if.meter        res
);

    logic        in_frame_q;   // a frame has started and not ended
    logic [11:0] cnt_q;        // bytes forwarded so far

    // the first byte restarts every accumulator
    wire         first   = !in_frame_q;
    wire  [11:0] idx     = first ? 12'h000 : cnt_q;
    wire         room    = (idx != rxs_pkg::WDOG_BYTES);
    wire         take    = frm_valid && room;
    wire         bc_base = first ? 1'b1 : res.bcast;
    wire         mc_base = first ? 1'b0 : res.mcast;
    wire         er_base = first ? 1'b0 : res.rx_er;
    wire         lc_base = first ? 1'b0 : res.late_col;
    wire  [15:0] lt_base = first ? 16'h0000 : res.len_type;
    wire         in_da   = (idx < rxs_pkg::DA_BYTES);
    wire         bc_d    = in_da ? (bc_base && (frm_data == rxs_pkg::BCAST_BYTE)) : bc_base;
    wire         mc_d    = (idx == 12'h000) ? frm_data[0] : mc_base;
    wire  [15:0] lt_d    = (idx == rxs_pkg::LT_HI_IDX) ? {frm_data, lt_base[7:0]} :
                           (idx == rxs_pkg::LT_LO_IDX) ? {lt_base[15:8], frm_data} : lt_base;

    // byte forwarding, bytes past 2048 are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxd_valid <= 1'b0;
            rxd_data  <= 8'h00;
        end else if (ce) begin
            rxd_valid <= take;
            if (take) begin
                rxd_data <= frm_data;
            end
        end
    end

    // frame tracking and header capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_frame_q   <= 1'b0;
            cnt_q        <= 12'h000;
            res.done     <= 1'b0;
            res.bcast    <= 1'b0;
            res.mcast    <= 1'b0;
            res.len_type <= 16'h0000;
            res.rx_er    <= 1'b0;
            res.late_col <= 1'b0;
        end else if (ce) begin
            res.done <= frm_valid && frm_last;
            if (frm_valid) begin
                in_frame_q   <= !frm_last;
                cnt_q        <= take ? idx + 12'h001 : idx;
                res.bcast    <= bc_d;
                res.mcast    <= mc_d;
                res.len_type <= lt_d;
                res.rx_er    <= er_base | frm_rx_er;
                res.late_col <= lc_base | frm_late_col;
            end
        end
    end

    // end-of-frame qualifiers sampled with the last byte
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res.crc_bad   <= 1'b0;
            res.drib_bits <= 3'h0;
            res.filt_pass <= 1'b0;
            res.da_fail   <= 1'b0;
        end else if (ce && frm_valid && frm_last) begin
            res.crc_bad   <= frm_crc_bad;
            res.drib_bits <= frm_drib_bits;
            res.filt_pass <= frm_filt_pass;
            res.da_fail   <= frm_da_fail;
        end
    end

    // final byte count
    assign res.bytes = cnt_q;

endmodule

`default_nettype wire

// >>> rtl/rxs_status_gen.sv
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - bit 31 set when frame filter passed
// - bit 30 set on address recognition failure
// - bits 29:16 hold frame byte count
// - bit 15 ORs runt, long, late, crc
// - bits 14, 9:8, 0 read zero
// - bit 13 marks broadcast destination
// - bit 12 marks length field mismatch
// - bit 11 marks frame under 64 bytes
// - runts kept only with pass-bad control set
// - bit 10 marks multicast, not broadcast, destination
// - bit 7 above 1518 bytes, no cut
// - bit 6 marks late collision
// - bit 5 set when type above 1500
// - frame type clear below 14 bytes
// - bit 4 at 2048 bytes or more
// - frames cut to 2048 bytes
// - bit 3 on receive error anytime
// - bit 2 flags non-octet bit count at 10 Mbps only
// - dribble needs three bits at 10 Mbps
// - no dribble flag with late collision
// - bit 1 on check fail or rx error
// - status word written after frame data

module rxs_status_gen #(
    parameter int DEPTH = 16   // status words held
) (
    // clock, reset and freeze
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // frame bytes from the fabric
    input  wire logic        frm_valid,
    input  wire logic [7:0]  frm_data,
    input  wire logic        frm_last,
    input  wire logic        frm_rx_er,
    input  wire logic        frm_late_col,
    input  wire logic        frm_crc_bad,
    input  wire logic [2:0]  frm_drib_bits,
    input  wire logic        frm_filt_pass,
    input  wire logic        frm_da_fail,
    // data queue side
    output logic             rxd_valid,
    output logic      [7:0]  rxd_data,
    output logic             rxd_commit,
    output logic             rxd_discard,
    // status queue state
    output logic             stat_avail
);

    localparam int AW = $clog2(DEPTH);

    typedef enum logic [1:0] {
        AH_IDLE,
        AH_WAIT,
        AH_RESP
    } rxs_ah_e;

    // offset compare used by every register decode
    function automatic logic ofs_hit(input logic [7:0] ofs, input logic [7:0] target);
        ofs_hit = (ofs == target);
    endfunction

    // bus state
    rxs_ah_e     ah_q;          // bus transfer phase
    rxs_ah_e     ah_d;
    logic [7:0]  a_ofs_q;       // latched register offset
    logic        a_wr_q;        // latched direction
    logic        rd_ok_q;       // queue had a word when the read was taken
    logic [31:0] hrdata_q;      // read data register

    // control register
    logic [1:0]  ctl_q;         // host_mac_control_reg

    // status queue state
    logic [AW-1:0] wr_ptr_q;    // next slot to fill
    logic [AW-1:0] rd_ptr_q;    // oldest word
    logic [AW:0]   lvl_q;       // words held
    logic [15:0]   drop_q;      // words lost to a full queue
    logic [31:0]   mem_rdata;   // head word from storage

    // per-frame results
    rxs_res_if res_bus();

    // byte meter
    rxs_frame_meter u_meter (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .ce            (ce),
        .frm_valid     (frm_valid),
        .frm_data      (frm_data),
        .frm_last      (frm_last),
        .frm_rx_er     (frm_rx_er),
        .frm_late_col  (frm_late_col),
        .frm_crc_bad   (frm_crc_bad),
        .frm_drib_bits (frm_drib_bits),
        .frm_filt_pass (frm_filt_pass),
        .frm_da_fail   (frm_da_fail),
        .rxd_valid     (rxd_valid),
        .rxd_data      (rxd_data),
        .res           (res_bus.meter)
    );

    // control fields
    wire pass_bad_frames_ctl = ctl_q[rxs_pkg::CTL_PASS_BAD];
    wire speed_10m           = ctl_q[rxs_pkg::CTL_SPEED10];

    // ---------------- status word assembly ----------------

    // byte count and length checks
    wire [11:0] nbytes    = res_bus.bytes;
    wire [15:0] nbytes16  = {4'h0, nbytes};
    wire [15:0] lt        = res_bus.len_type;
    wire        has_hdr   = (nbytes >= rxs_pkg::HDR_BYTES);
    wire        runt      = (nbytes < rxs_pkg::RUNT_BYTES);
    wire        too_long  = (nbytes > rxs_pkg::LONG_BYTES);
    wire        wdog      = (nbytes == rxs_pkg::WDOG_BYTES);
    wire        is_type   = has_hdr && (lt > rxs_pkg::TYPE_MIN);
    wire [15:0] exp_len   = lt + rxs_pkg::OVERHEAD;
    wire        padded_ok = (lt < rxs_pkg::PAD_LIMIT) && (nbytes == rxs_pkg::RUNT_BYTES);
    wire        len_err   = has_hdr && !is_type && (nbytes16 != exp_len) && !padded_ok;

    // error bits
    wire        late_col  = res_bus.late_col;
    wire        mii_err   = res_bus.rx_er;
    wire        crc_err   = res_bus.crc_bad | res_bus.rx_er;
    wire        drib_any  = (res_bus.drib_bits != 3'h0);
    wire        drib      = drib_any && speed_10m && !late_col &&
                            (res_bus.drib_bits >= rxs_pkg::DRIB_MIN);
    wire        err_sum   = runt | too_long | late_col | crc_err;

    logic [31:0] stat_word;     // word for the current frame

    // places each flag; untouched positions stay zero
    always_comb begin
        stat_word                                      = 32'h0000_0000;
        stat_word[rxs_pkg::B_FILT]                     = res_bus.filt_pass;
        stat_word[rxs_pkg::B_DA_FAIL]                  = res_bus.da_fail;
        stat_word[rxs_pkg::B_LEN_HI:rxs_pkg::B_LEN_LO] = {2'b00, nbytes};
        stat_word[rxs_pkg::B_ES]                       = err_sum;
        stat_word[rxs_pkg::B_BCAST]                    = res_bus.bcast;
        stat_word[rxs_pkg::B_LEN_ERR]                  = len_err;
        stat_word[rxs_pkg::B_RUNT]                     = runt;
        stat_word[rxs_pkg::B_MCAST]                    = res_bus.mcast && !res_bus.bcast;
        stat_word[rxs_pkg::B_LONG]                     = too_long;
        stat_word[rxs_pkg::B_LATE_COL]                 = late_col;
        stat_word[rxs_pkg::B_TYPE]                     = is_type;
        stat_word[rxs_pkg::B_WDOG]                     = wdog;
        stat_word[rxs_pkg::B_MII]                      = mii_err;
        stat_word[rxs_pkg::B_DRIB]                     = drib;
        stat_word[rxs_pkg::B_CRC]                      = crc_err;
    end

    // ---------------- frame commit ----------------

    // queue fill state
    wire q_full  = (lvl_q == (AW+1)'(DEPTH));
    wire q_empty = (lvl_q == '0);

    // a runt without pass-bad, or no room for its word, drops the frame whole
    wire runt_drop = runt && !pass_bad_frames_ctl;
    wire keep      = !runt_drop && !q_full;
    wire push      = ce && res_bus.done && keep;

    // data queue keeps or rewinds the bytes it already holds
    assign rxd_commit  = push;
    assign rxd_discard = ce && res_bus.done && !keep;
    assign stat_avail  = !q_empty;

    // ---------------- register bus ----------------

    // address phase taken when selected and the bus is ready
    wire take_req = hsel && htrans[1] && hready;

    // register decode on the latched offset
    wire sel_ctl  = ofs_hit(a_ofs_q, rxs_pkg::OFS_CTL);
    wire sel_stat = ofs_hit(a_ofs_q, rxs_pkg::OFS_STAT);
    wire sel_info = ofs_hit(a_ofs_q, rxs_pkg::OFS_INFO);
    wire in_wait  = (ah_q == AH_WAIT);

    // register accesses happen in the wait cycle of the data phase
    wire wr_ctl   = in_wait && a_wr_q && sel_ctl;
    wire wr_info  = in_wait && a_wr_q && sel_info;
    wire pop      = ce && in_wait && !a_wr_q && sel_stat && rd_ok_q;

    // read data selection
    wire [31:0] info_word = {drop_q, {(16 - AW - 1){1'b0}}, lvl_q};
    wire [31:0] rd_mux    = sel_ctl  ? {30'h0000_0000, ctl_q} :
                            sel_stat ? (rd_ok_q ? mem_rdata : 32'h0000_0000) :
                            sel_info ? info_word : 32'h0000_0000;

    // every transfer gets one wait cycle so read data come from a register
    always_comb begin
        ah_d = ah_q;
        case (ah_q)
            AH_IDLE: begin
                if (take_req) begin
                    ah_d = AH_WAIT;
                end
            end
            AH_WAIT: begin
                ah_d = AH_RESP;
            end
            AH_RESP: begin
                ah_d = take_req ? AH_WAIT : AH_IDLE;
            end
            default: begin
                ah_d = AH_IDLE;
            end
        endcase
    end

    // bus handshake outputs
    assign hreadyout = (ah_q != AH_WAIT);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // bus phase and address capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ah_q    <= AH_IDLE;
            a_ofs_q <= 8'h00;
            a_wr_q  <= 1'b0;
            rd_ok_q <= 1'b0;
        end else if (ce) begin
            ah_q <= ah_d;
            if (take_req) begin
                a_ofs_q <= haddr[7:0];
                a_wr_q  <= hwrite;
                rd_ok_q <= !q_empty;
            end
        end
    end

    // read data register and control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
            ctl_q    <= rxs_pkg::CTL_RST;
        end else if (ce) begin
            if (in_wait && !a_wr_q) begin
                hrdata_q <= rd_mux;
            end
            if (wr_ctl) begin
                ctl_q <= hwdata[1:0];
            end
        end
    end

    // ---------------- status queue ----------------

    // lost-word counter: a loss in the clearing cycle still counts
    wire        lost      = ce && res_bus.done && !runt_drop && q_full;
    wire [15:0] drop_base = wr_info ? 16'h0000 : drop_q;
    wire [15:0] drop_d    = (lost && (drop_base != 16'hFFFF)) ? drop_base + 16'h0001 : drop_base;

    // pointers and level, words leave in arrival order
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            lvl_q    <= '0;
            drop_q   <= 16'h0000;
        end else if (ce) begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                lvl_q <= lvl_q + 1'b1;
            end else if (pop && !push) begin
                lvl_q <= lvl_q - 1'b1;
            end
            drop_q <= drop_d;
        end
    end

    // status word storage, read issued with the address phase
    rxs_stat_mem #(
        .W     (32),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .we      (push),
        .waddr   (wr_ptr_q),
        .wdata   (stat_word),
        .re      (take_req),
        .raddr   (rd_ptr_q),
        .rdata_q (mem_rdata)
    );

endmodule

`default_nettype wire

// >>> tb/rxs_status_gen_properties.sv
`timescale 1ns/1ps
`default_nettype none
// bus handshake and frame completion checks
module rxs_status_gen_chk (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    // frame side
    input wire logic        frm_valid,
    input wire logic        frm_last,
    input wire logic        rxd_valid,
    input wire logic        rxd_commit,
    input wire logic        rxd_discard,
    input wire logic        stat_avail
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic tk = hsel && htrans[1] && hready && ce;  // request taken
    wire logic fe = frm_valid && frm_last && ce;        // frame end taken
    sequence s_resp; !hreadyout ##1 hreadyout; endsequence
    property p_wait; tk |=> s_resp; endproperty
    a_wait: assert property (p_wait) else $error("bus wait not single");
    property p_ready; !tk |=> hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait without request");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_end; fe |=> (rxd_commit ^ rxd_discard); endproperty
    a_end: assert property (p_end) else $error("frame end unresolved");
    property p_avail; rxd_commit |=> stat_avail; endproperty
    a_avail: assert property (p_avail) else $error("word not queued");
    property p_tail; rxd_commit |-> $past(fe); endproperty
    a_tail: assert property (p_tail) else $error("word before data");
    property p_quiet; !frm_valid && ce |=> !rxd_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray byte");
    property p_hold; !ce |=> $stable(hrdata) && $stable(stat_avail); endproperty
    a_hold: assert property (p_hold) else $error("moved while frozen");
endmodule
bind rxs_status_gen rxs_status_gen_chk i_rxs_status_gen_chk (.hclk, .hresetn, .ce, .hsel, .htrans, .hready,
    .hreadyout, .hresp, .hrdata, .frm_valid, .frm_last, .rxd_valid, .rxd_commit, .rxd_discard, .stat_avail);
`default_nettype wire

// >>> tb/rxs_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
// fabric side: one frame byte per clock, no back-pressure
module rxs_fabric_model (
    // clock
    input  wire logic      hclk,
    // frame bytes
    output var logic       frm_valid,
    output var logic [7:0] frm_data,
    output var logic       frm_last,
    // per-frame flags
    output var logic       frm_rx_er,
    output var logic       frm_late_col,
    output var logic       frm_crc_bad,
    output var logic [2:0] frm_drib_bits,
    output var logic       frm_filt_pass,
    output var logic       frm_da_fail
);
    // quiet link at time zero
    initial begin
        {frm_valid, frm_last, frm_rx_er, frm_late_col, frm_crc_bad} = 5'h00;
        {frm_filt_pass, frm_da_fail, frm_drib_bits, frm_data} = 13'h0055;
    end
    // f holds rx error, late collision, crc, filter pass, address fail
    task automatic send(input int n, input logic [7:0] da, input logic [15:0] lt,
                        input logic [4:0] f, input logic [2:0] d);
        for (int i = 0; i < n; i++) begin
            frm_valid <= 1'b1;
            frm_data  <= i < 6 ? da : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'h00;
            frm_last  <= i == n - 1;
            {frm_rx_er, frm_late_col, frm_crc_bad, frm_filt_pass, frm_da_fail} <= f;
            frm_drib_bits <= d;
            @(posedge hclk);
        end
    endtask
    // released link: data flips so no stale byte lingers
    task automatic idle();
        frm_valid <= 1'b0;
        frm_last  <= 1'b0;
        frm_data  <= ~frm_data;
        @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// >>> tb/rx_status_word_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_status_word_gen_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    wire logic   hreadyout, hresp, rxd_valid, rxd_commit, rxd_discard, stat_avail;
    wire logic   frm_valid, frm_last, frm_rx_er, frm_late_col, frm_crc_bad, frm_filt_pass, frm_da_fail;
    wire logic [31:0] hrdata;
    wire logic [7:0]  rxd_data, frm_data;
    wire logic [2:0]  frm_drib_bits;
    int          error_cnt = 0, compares = 0, cyc = 0, nfw = 0, sfw = 0;
    always #50 hclk = ~hclk;
    rxs_status_gen i_rxs_status_gen (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frm_valid, .frm_data, .frm_last,
        .frm_rx_er, .frm_late_col, .frm_crc_bad, .frm_drib_bits, .frm_filt_pass, .frm_da_fail,
        .rxd_valid, .rxd_data, .rxd_commit, .rxd_discard, .stat_avail);
    rxs_fabric_model i_rxs_fabric_model (.hclk, .frm_valid, .frm_data, .frm_last, .frm_rx_er,
        .frm_late_col, .frm_crc_bad, .frm_drib_bits, .frm_filt_pass, .frm_da_fail);
    // forwarded byte count and hang guard
    always @(posedge hclk) begin
        nfw = nfw + int'(rxd_valid === 1'b1);
        sfw = sfw + ((rxd_valid === 1'b1) ? int'(rxd_data) : 0);
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // single word transfer, held until hready seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, a};
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        {hsel, htrans} <= 3'h0;
        hwdata <= wd;
        @(negedge hclk);
        while (hreadyout !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask
    task automatic wr(input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, rxs_pkg::OFS_CTL, d, r);
    endtask
    task automatic s_word();
        wr(32'h0000_0000);
        i_rxs_fabric_model.send(64, 8'hFF, 16'h0800, 5'h06, 3'h3);
        i_rxs_fabric_model.idle();
        rdc(rxs_pkg::OFS_STAT, 32'h8040_A022);
    endtask
    task automatic s_runt();
        i_rxs_fabric_model.send(20, 8'h02, 16'h0800, 5'h00, 3'h0);
        i_rxs_fabric_model.idle();
        rdc(rxs_pkg::OFS_STAT, 32'h0000_0000);
        wr(32'h0000_0003);
        i_rxs_fabric_model.send(10, 8'h01, 16'h0800, 5'h18, 3'h3);
        i_rxs_fabric_model.idle();
        rdc(rxs_pkg::OFS_STAT, 32'h000A_8C4A);
    endtask
    task automatic s_long();
        wr(32'h0000_0002);
        nfw = 0;
        sfw = 0;
        i_rxs_fabric_model.send(2100, 8'h02, 16'h0800, 5'h01, 3'h3);
        i_rxs_fabric_model.idle();
        chk(nfw, 32'h0000_0800);
        chk(sfw, 32'h0000_0014);
        rdc(rxs_pkg::OFS_STAT, 32'h4800_80B4);
    endtask
    task automatic s_order();
        wr(32'h0000_0000);
        ce <= 1'b0;
        @(posedge hclk);
        ce <= 1'b1;
        i_rxs_fabric_model.send(100, 8'h02, 16'h0010, 5'h00, 3'h7);
        i_rxs_fabric_model.send(64, 8'h02, 16'h002E, 5'h00, 3'h0);
        i_rxs_fabric_model.idle();
        rdc(rxs_pkg::OFS_INFO, 32'h0000_0002);
        rdc(rxs_pkg::OFS_STAT, 32'h0064_1000);
        rdc(rxs_pkg::OFS_STAT, 32'h0040_0000);
        rdc(8'h0C, 32'h0000_0000);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        s_word();
        s_runt();
        s_long();
        s_order();
        stop_test();
    end
endmodule
`default_nettype wire
